// [verilog/pfsel_mux.sv]
/*
  pfsel_mux: two function-select registers and the pin routing they steer
  for port b (uart pins) and port c (lin pins).
  assumes: single-cycle register strobes on sys_clk; pad inputs asynchronous;
  uart and lin transceiver signals are on sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// RULE_01: port b register resets to 0x10000000
// RULE_02: port b bit 4 routes uart transmit
// RULE_03: port b bit 0 routes uart receive
// RULE_04: port c register resets to 0x01000000
// RULE_05: port c bit 20 routes uart to lin
// RULE_06: port c bit 16 enables lin input path
// RULE_07: port c bit 4 also enables lin input
// RULE_08: port c bit 0 passes pin to transceiver
// RULE_09: software sets bits 20 and 16 for lin
// RULE_10: software writes zero to reserved bits
// RULE_11: writes act next cycle; reserved bits store
module pfsel_mux (
  // clock, reset, enable
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic        clk_en,
  // register port
  input  wire logic [31:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output var  logic [31:0] reg_rdata,
  // port b pads (rx pin, tx pin)
  input  wire logic        pb_rx_pad_in,
  output var  logic        pb_tx_pad_out,
  output var  logic        pb_tx_pad_oe,
  // port b gpio side
  input  wire logic        pb_gpio_tx_out,
  input  wire logic        pb_gpio_tx_oe,
  output var  logic        pb_gpio_rx_in,
  output var  logic        pb_gpio_tx_in,
  // uart
  input  wire logic        uart_txd,
  output var  logic        uart_rxd,
  // port c: lin transceiver and gpio
  input  wire logic        lin_rx_data,
  output var  logic        lin_tx_data,
  output var  logic        lin_sync_rx,
  output var  logic        diag_readback,
  input  wire logic        pc_diag_in,
  input  wire logic        pc_gpio_tx_out,
  input  wire logic        pc_xcvr_pad_in,
  output var  logic        pc_xcvr_gpio_in,
  output var  logic        pc_xcvr_tx
);
  import pfsel_pkg::*;

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  function automatic logic hit(input logic [31:0] a, input logic [31:0] o);
    hit = (a == o);
  endfunction : hit

  logic [31:0] port_b_function_select_reg;
  logic [31:0] port_b_function_select_next;
  logic [31:0] port_c_function_select_reg;
  logic [31:0] port_c_function_select_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;

  always_comb begin
    port_b_function_select_next = port_b_function_select_reg;
    port_c_function_select_next = port_c_function_select_reg;
    rdata_next                  = 32'h00000000;
    if (reg_wr && hit(reg_addr, PFSEL_PORT_B_OFS)) begin
      port_b_function_select_next = reg_wdata; // RULE_11
    end
    if (reg_wr && hit(reg_addr, PFSEL_PORT_C_OFS)) begin
      port_c_function_select_next = reg_wdata; // RULE_11
    end
    if (reg_rd && hit(reg_addr, PFSEL_PORT_B_OFS)) begin
      rdata_next = port_b_function_select_reg;
    end else if (reg_rd && hit(reg_addr, PFSEL_PORT_C_OFS)) begin
      rdata_next = port_c_function_select_reg;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      port_b_function_select_reg <= PFSEL_PORT_B_RST; // RULE_01
      port_c_function_select_reg <= PFSEL_PORT_C_RST; // RULE_04
      rdata_reg                  <= 32'h00000000;
    end else if (clk_en) begin
      port_b_function_select_reg <= port_b_function_select_next;
      port_c_function_select_reg <= port_c_function_select_next;
      rdata_reg                  <= rdata_next;
    end
  end

  // ---------------------------------------------------------------
  // pad synchronisers
  // ---------------------------------------------------------------
  logic pb_rx_s;
  logic lin_rx_s;
  logic diag_s;
  logic xcvr_s;

  pfsel_sync u_sync_pb_rx (
    .sys_clk (sys_clk), .sys_rst (sys_rst), .clk_en (clk_en),
    .pin_in  (pb_rx_pad_in), .pin_out (pb_rx_s)
  );
  pfsel_sync u_sync_lin_rx (
    .sys_clk (sys_clk), .sys_rst (sys_rst), .clk_en (clk_en),
    .pin_in  (lin_rx_data), .pin_out (lin_rx_s)
  );
  pfsel_sync u_sync_diag (
    .sys_clk (sys_clk), .sys_rst (sys_rst), .clk_en (clk_en),
    .pin_in  (pc_diag_in), .pin_out (diag_s)
  );
  pfsel_sync u_sync_xcvr (
    .sys_clk (sys_clk), .sys_rst (sys_rst), .clk_en (clk_en),
    .pin_in  (pc_xcvr_pad_in), .pin_out (xcvr_s)
  );

  // ---------------------------------------------------------------
  // routing
  // ---------------------------------------------------------------
  logic b_txd_sel;
  logic b_rxd_sel;
  logic c_tx_sel;
  logic c_rx_sel;
  logic c_xcvr_sel;
  logic [10:1] out_reg;
  logic [10:1] out_next;

  assign b_txd_sel  = port_b_function_select_reg[PFSEL_B_TXD_BIT];
  assign b_rxd_sel  = port_b_function_select_reg[PFSEL_B_RXD_BIT];
  assign c_tx_sel   = port_c_function_select_reg[PFSEL_C_TX_BIT];
  // either documented bit opens the lin input path
  assign c_rx_sel   = port_c_function_select_reg[PFSEL_C_RX_BIT]
                    | port_c_function_select_reg[PFSEL_C_RXALT_BIT]; // RULE_07
  assign c_xcvr_sel = port_c_function_select_reg[PFSEL_C_XCVR_BIT];

  always_comb begin
    // out_next: {xcvr_tx, xcvr_gpio_in, diag, sync, lin_tx, urxd,
    //            gtx_in, grx_in, tx_oe, tx_out}
    out_next[10] = c_xcvr_sel & xcvr_s;                    // RULE_08
    out_next[9]  = c_xcvr_sel ? 1'b0 : xcvr_s;             // RULE_08
    out_next[8]  = c_rx_sel ? 1'b0 : diag_s;               // RULE_06
    out_next[7]  = c_rx_sel & lin_rx_s;                    // RULE_06
    out_next[6]  = c_tx_sel ? uart_txd : pc_gpio_tx_out;   // RULE_05
    // uart receive idles high when neither source is routed
    out_next[5]  = b_rxd_sel ? pb_rx_s
                 : (c_rx_sel ? lin_rx_s : 1'b1);           // RULE_03
    out_next[4]  = b_txd_sel ? 1'b0 : pb_rx_s;
    out_next[3]  = b_rxd_sel ? 1'b0 : pb_rx_s;             // RULE_03
    out_next[2]  = b_txd_sel ? 1'b1 : pb_gpio_tx_oe;       // RULE_02
    out_next[1]  = b_txd_sel ? uart_txd : pb_gpio_tx_out;  // RULE_02
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      out_reg <= 10'h010;
    end else if (clk_en) begin
      out_reg <= out_next;
    end
  end

  assign pc_xcvr_tx      = out_reg[10];
  assign pc_xcvr_gpio_in = out_reg[9];
  assign diag_readback   = out_reg[8];
  assign lin_sync_rx     = out_reg[7];
  assign lin_tx_data     = out_reg[6];
  assign uart_rxd        = out_reg[5];
  assign pb_gpio_tx_in   = out_reg[4];
  assign pb_gpio_rx_in   = out_reg[3];
  assign pb_tx_pad_oe    = out_reg[2];
  assign pb_tx_pad_out   = out_reg[1];
  assign reg_rdata       = rdata_reg;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  sequence s_wr_b;
    reg_wr && clk_en && hit(reg_addr, PFSEL_PORT_B_OFS);
  endsequence
  sequence s_wr_c;
    reg_wr && clk_en && hit(reg_addr, PFSEL_PORT_C_OFS);
  endsequence

  a_reset_b_val: assert property (@(posedge sys_clk) // RULE_01
    $past(sys_rst) |-> port_b_function_select_reg == 32'h10000000)
    else $error("port b reset value wrong");
  a_reset_c_val: assert property (@(posedge sys_clk) // RULE_04
    $past(sys_rst) |-> port_c_function_select_reg == 32'h01000000)
    else $error("port c reset value wrong");
  a_write_b_store: assert property (@(posedge sys_clk) // RULE_11
    disable iff (sys_rst) s_wr_b |=> port_b_function_select_reg ==
    $past(reg_wdata)) else $error("port b write lost");
  a_write_c_store: assert property (@(posedge sys_clk) // RULE_11
    disable iff (sys_rst) s_wr_c |=> port_c_function_select_reg ==
    $past(reg_wdata)) else $error("port c write lost");
  a_txd_route: assert property (@(posedge sys_clk) // RULE_02
    disable iff (sys_rst) clk_en && b_txd_sel |=>
    pb_tx_pad_out == $past(uart_txd) && pb_tx_pad_oe)
    else $error("uart tx not on port b pin");
  a_rxd_route: assert property (@(posedge sys_clk) // RULE_03
    disable iff (sys_rst) clk_en && b_rxd_sel |=>
    uart_rxd == $past(pb_rx_s) && !pb_gpio_rx_in)
    else $error("port b rx not to uart");
  a_lin_tx_route: assert property (@(posedge sys_clk) // RULE_05
    disable iff (sys_rst) clk_en |=> lin_tx_data ==
    ($past(c_tx_sel) ? $past(uart_txd) : $past(pc_gpio_tx_out)))
    else $error("lin tx source wrong");
  a_lin_rx_gate: assert property (@(posedge sys_clk) // RULE_06
    disable iff (sys_rst) clk_en && !c_rx_sel |=>
    !lin_sync_rx && diag_readback == $past(diag_s))
    else $error("lin rx not gated");
  a_rx_alt_bit: assert property (@(posedge sys_clk) // RULE_07
    disable iff (sys_rst) clk_en && !b_rxd_sel &&
    port_c_function_select_reg[PFSEL_C_RXALT_BIT] |=>
    uart_rxd == $past(lin_rx_s)) else $error("alt rx bit ignored");
  a_xcvr_pass: assert property (@(posedge sys_clk) // RULE_08
    disable iff (sys_rst) clk_en && !c_xcvr_sel |=> !pc_xcvr_tx)
    else $error("transceiver driven in gpio mode");
  a_read_data: assert property (@(posedge sys_clk) // RULE_11
    disable iff (sys_rst) reg_rd && clk_en && hit(reg_addr,
    PFSEL_PORT_C_OFS) |=> reg_rdata == $past(port_c_function_select_reg))
    else $error("port c readback wrong");
endmodule : pfsel_mux
`default_nettype wire

// [pkg/pfsel_pkg.sv]
/*
  pfsel_pkg: register offsets, reset values and field positions for the
  port b / port c pin-function multiplexer.
  assumes: a 32-bit register port with word-aligned byte addresses.
*/
`default_nettype none
package pfsel_pkg;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [31:0] PFSEL_PORT_B_OFS   = 32'hfff6dd04;
  localparam logic [31:0] PFSEL_PORT_C_OFS   = 32'hffff0d08;
  localparam logic [31:0] PFSEL_PORT_B_RST   = 32'h10000000;
  localparam logic [31:0] PFSEL_PORT_C_RST   = 32'h01000000;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int          PFSEL_B_RXD_BIT    = 0;
  localparam int          PFSEL_B_TXD_BIT    = 4;
  localparam int          PFSEL_C_XCVR_BIT   = 0;
  localparam int          PFSEL_C_RXALT_BIT  = 4;
  localparam int          PFSEL_C_RX_BIT     = 16;
  localparam int          PFSEL_C_TX_BIT     = 20;
  // ---------------------------------------------------------------
  // pin input synchroniser depth
  // ---------------------------------------------------------------
  localparam int          PFSEL_SYNC_DEPTH   = 3;
endpackage : pfsel_pkg
`default_nettype wire

// [verilog/pfsel_sync.sv]
/*
  pfsel_sync: three-stage synchroniser for pad inputs; the value moves on
  only when stages two and three agree.
  assumes: the input is asynchronous to sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module pfsel_sync (
  // clock, reset, enable
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  input  wire logic clk_en,
  // data
  input  wire logic pin_in,
  output var  logic pin_out
);
  import pfsel_pkg::*;

  logic [PFSEL_SYNC_DEPTH-1:0] stage_reg;
  logic [PFSEL_SYNC_DEPTH-1:0] stage_next;
  logic                        out_reg;
  logic                        out_next;

  always_comb begin
    stage_next = {stage_reg[PFSEL_SYNC_DEPTH-2:0], pin_in};
    out_next   = out_reg;
    if (stage_reg[1] == stage_reg[2]) begin
      out_next = stage_reg[2];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      stage_reg <= '0;
      out_reg   <= 1'b0;
    end else if (clk_en) begin
      stage_reg <= stage_next;
      out_reg   <= out_next;
    end
  end

  assign pin_out = out_reg;
endmodule : pfsel_sync
`default_nettype wire

// [testbench/pfsel_far_model.sv]
/* pfsel_far_model: uart, lin transceiver and pad levels at the far side.
   assumes: the bench picks the levels; they change after sys_clk edges. */
`timescale 1ns/1ps
`default_nettype none
module pfsel_far_model (
  // clock
  input  wire logic sys_clk,
  // levels asked for by the bench
  input  wire logic tx_lvl,
  input  wire logic rx_lvl,
  input  wire logic pad_lvl,
  // toward the mux
  output var  logic uart_txd,
  output var  logic lin_rx_data,
  output var  logic pb_rx_pad_in,
  output var  logic pc_xcvr_pad_in,
  output var  logic pc_diag_in
);
  // diag pad shows the inverse so it never matches the lin level by luck
  initial {uart_txd, lin_rx_data, pb_rx_pad_in, pc_xcvr_pad_in} = 4'h0;
  initial pc_diag_in = 1'b1;
  always @(posedge sys_clk) begin
    uart_txd       <= tx_lvl;
    lin_rx_data    <= rx_lvl;
    pb_rx_pad_in   <= pad_lvl;
    pc_xcvr_pad_in <= pad_lvl;
    pc_diag_in     <= ~pad_lvl;
  end
endmodule : pfsel_far_model
`default_nettype wire

// [testbench/pfsel_mux_tb_top.sv]
/* pfsel_mux_tb_top: self-checking bench for the port b / port c mux.
   assumes: pfsel_pkg compiled first; 25 MHz sys_clk. */
`timescale 1ns/1ps
`default_nettype none
module pfsel_mux_tb_top;
  import pfsel_pkg::*;
  logic        sys_clk, sys_rst, clk_en, reg_wr, reg_rd;
  logic [31:0] reg_addr, reg_wdata, reg_rdata;
  logic        pb_rx_pad_in, pb_tx_pad_out, pb_tx_pad_oe, pb_gpio_tx_out;
  logic        pb_gpio_tx_oe, pb_gpio_rx_in, pb_gpio_tx_in, uart_txd;
  logic        uart_rxd, lin_rx_data, lin_tx_data, lin_sync_rx;
  logic        diag_readback, pc_diag_in, pc_gpio_tx_out, pc_xcvr_pad_in;
  logic        pc_xcvr_gpio_in, pc_xcvr_tx, tx_lvl, rx_lvl, pad_lvl;
  int          bad_count, n_checks;
  // -----------------------------------------------------------------
  // clock, design, far side
  // -----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  pfsel_mux dut_u (.sys_clk, .sys_rst, .clk_en, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .pb_rx_pad_in, .pb_tx_pad_out,
    .pb_tx_pad_oe, .pb_gpio_tx_out, .pb_gpio_tx_oe, .pb_gpio_rx_in,
    .pb_gpio_tx_in, .uart_txd, .uart_rxd, .lin_rx_data, .lin_tx_data,
    .lin_sync_rx, .diag_readback, .pc_diag_in, .pc_gpio_tx_out,
    .pc_xcvr_pad_in, .pc_xcvr_gpio_in, .pc_xcvr_tx);
  pfsel_far_model far_u (.sys_clk, .tx_lvl, .rx_lvl, .pad_lvl, .uart_txd,
    .lin_rx_data, .pb_rx_pad_in, .pc_xcvr_pad_in, .pc_diag_in);
  // -----------------------------------------------------------------
  // shared tasks
  // -----------------------------------------------------------------
  task automatic chk1(input string n, input logic e, input logic g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s exp %b got %b", n, e, g);
    end
  endtask : chk1
  task automatic chk32(input string n, input logic [31:0] e,
                       input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask : chk32
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask : wr
  task automatic rdchk(input string n, input logic [31:0] a,
                       input logic [31:0] e);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk32(n, e, reg_rdata);
    @(posedge sys_clk);
  endtask : rdchk
  // program both selects, set far-side levels, let pad syncs settle
  task automatic route(input logic [31:0] b, input logic [31:0] c,
                       input logic l);
    @(posedge sys_clk);
    wr(PFSEL_PORT_B_OFS, b);
    wr(PFSEL_PORT_C_OFS, c);
    tx_lvl         <= ~l;
    rx_lvl         <= l;
    pad_lvl        <= l;
    pb_gpio_tx_out <= l;
    pb_gpio_tx_oe  <= l;
    pc_gpio_tx_out <= l;
    repeat (10) @(posedge sys_clk);
    #1;
  endtask : route
  // -----------------------------------------------------------------
  // scenarios
  // -----------------------------------------------------------------
  task automatic t_reset;
    rdchk("b_rst", PFSEL_PORT_B_OFS, PFSEL_PORT_B_RST);
    rdchk("c_rst", PFSEL_PORT_C_OFS, PFSEL_PORT_C_RST);
    rdchk("unmapped", 32'hffff0d0c, 32'h00000000);
    $display("test reset done");
  endtask : t_reset
  task automatic t_regs;
    wr(PFSEL_PORT_B_OFS, 32'hffffffef);
    wr(PFSEL_PORT_C_OFS, 32'h5a5a5a5a);
    wr(32'hffff0d0c, 32'h00000000);
    clk_en <= 1'b0;
    wr(PFSEL_PORT_B_OFS, 32'h00000000);
    clk_en <= 1'b1;
    rdchk("b_bits", PFSEL_PORT_B_OFS, 32'hffffffef);
    rdchk("c_bits", PFSEL_PORT_C_OFS, 32'h5a5a5a5a);
    $display("test regs done");
  endtask : t_regs
  task automatic t_portb;
    for (int i = 0; i < 8; i++) begin
      logic [31:0] b;
      logic        l;
      b = {27'h0, i[1], 3'h0, i[0]};
      l = i[2];
      route(b, 32'h00000000, l);
      chk1("pb_tx", b[4] ? ~l : l, pb_tx_pad_out);
      chk1("pb_oe", b[4] ? 1'b1 : l, pb_tx_pad_oe);
      chk1("pb_tx_gpio", b[4] ? 1'b0 : l, pb_gpio_tx_in);
      chk1("uart_rxd", b[0] ? l : 1'b1, uart_rxd);
      chk1("pb_rx_gpio", b[0] ? 1'b0 : l, pb_gpio_rx_in);
    end
    $display("test portb done");
  endtask : t_portb
  // c with bits 20 and 16 set (i bits 3 and 2) is the lin operating setting
  task automatic t_portc;
    for (int i = 0; i < 32; i++) begin
      logic [31:0] c;
      logic        l;
      logic        op;
      c = {11'h0, i[3], 3'h0, i[2], 11'h0, i[1], 3'h0, i[0]};
      l = i[4];
      op = c[16] | c[4];
      route(32'h00000000, c, l);
      chk1("lin_tx", c[20] ? ~l : l, lin_tx_data);
      chk1("lin_sync", op & l, lin_sync_rx);
      chk1("uart_rxd", op ? l : 1'b1, uart_rxd);
      chk1("diag", op ? 1'b0 : ~l, diag_readback);
      chk1("xcvr_tx", c[0] & l, pc_xcvr_tx);
      chk1("xcvr_gpio", c[0] ? 1'b0 : l, pc_xcvr_gpio_in);
    end
    $display("test portc done");
  endtask : t_portc
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : summarize
  initial begin
    repeat (3000) @(posedge sys_clk);
    bad_count++;
    $display("[ERR] watchdog exp done got hang");
    summarize();
  end
  initial begin
    {sys_rst, clk_en} = 2'b11;
    {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    {tx_lvl, rx_lvl, pad_lvl} = 3'h0;
    {pb_gpio_tx_out, pb_gpio_tx_oe, pc_gpio_tx_out} = 3'h0;
    bad_count = 0;
    n_checks = 0;
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    t_reset();
    t_regs();
    t_portb();
    t_portc();
    summarize();
  end
endmodule : pfsel_mux_tb_top
`default_nettype wire
